// ==== design/zone_eval_pkg.sv ====
// package: constants and types for the alarm zone evaluator
package zone_eval_pkg;
  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int NZONE         = 8;
  localparam int NPART         = 4;
  localparam int CLK_HZ        = 50000000;
  localparam int SETTLE_MS     = 300;   // 0.3 s persistence
  localparam int SETTLE_CYC    = (CLK_HZ / 1000) * SETTLE_MS;
  localparam logic [7:0] CYC_UNLIMITED = 8'hFF;
  localparam logic [7:0] CYC_NONE      = 8'h00;

  // line condition from the detector
  typedef enum logic [2:0] {
    LINE_OPEN   = 3'h0,
    LINE_SHORT  = 3'h1,
    LINE_ONE_R  = 3'h2,
    LINE_TWO_R  = 3'h3,
    LINE_FAULT  = 3'h4,
    LINE_UNBAL  = 3'h5
  } line_type;

  typedef enum logic [2:0] {
    BAL_OPEN_IDLE   = 3'h0,
    BAL_CLOSED_IDLE = 3'h1,
    BAL_SINGLE_R    = 3'h2,
    BAL_DOUBLE_R    = 3'h3,
    BAL_TRIPLE_R    = 3'h4
  } balance_type;

  typedef enum logic [2:0] {
    ZT_INSTANT    = 3'h0,
    ZT_ENTRY      = 3'h1,
    ZT_ENTRY_PATH = 3'h2,
    ZT_EXIT       = 3'h3,
    ZT_LAST_EXIT  = 3'h4,
    ZT_H24        = 3'h5,
    ZT_FIRE       = 3'h6,
    ZT_HOLDUP     = 3'h7
  } ztype_type;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'h0,
    ST_ALARM   = 2'h1,
    ST_TAMPER  = 2'h2,
    ST_FAULT   = 2'h3
  } zstate_type;

  // per-zone configuration
  typedef struct packed {
    balance_type       balance;
    ztype_type         ztype;
    logic [NPART-1:0]  parts;
    logic              bypass;
    logic              test;
    logic              fault_opt;
    logic [7:0]        cycles;
  } zcfg_type;

  // per-partition state
  typedef struct packed {
    logic armed;
    logic entry_run;
    logic exit_run;
  } pstate_type;
endpackage

// ==== design/zone_filter.sv ====
// single zone line persistence filter
`timescale 1ns/1ps
module zone_filter
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire zone_eval_pkg::line_type raw,
  output zone_eval_pkg::line_type      stable
);
  import zone_eval_pkg::*;
  logic [2:0]  s1_q;
  logic [2:0]  s2_q;
  logic [2:0]  cand_q;
  logic [24:0] cnt_q;
  line_type    stable_q;

  // two-stage synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  // accept only after an unchanged run of the settle time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cand_q   <= 3'h0;
      cnt_q    <= 25'h0;
      stable_q <= LINE_OPEN;
    end else if (s2_q != cand_q) begin
      cand_q <= s2_q;
      cnt_q  <= 25'h0;
    end else if (cnt_q < 25'(SETTLE_CYC - 1)) begin
      cnt_q <= cnt_q + 25'h1;
    end else begin
      stable_q <= line_type'(cand_q);
    end
  end

  assign stable = stable_q;

  AST_SETTLE: assert property (@(posedge clk) disable iff (!rst_n)
    (stable_q != $past(stable_q)) |-> (cnt_q == 25'(SETTLE_CYC - 1)))
    else $error("line accepted before settle time");
endmodule

// ==== design/alarm_zone_evaluator.sv ====
// alarm zone evaluator: balance decode and zone type event logic
//
// Behaviour
// - act only on line stable 0.3 s
// - open-idle: open standby, negative alarm
// - closed-idle: negative standby, open alarm
// - single resistor: load standby, short tamper
// - tamper raises zone and partition tamper
// - double resistor: two standby, one violation
// - triple adds shared anonymous sensor fault event
// - triple balance only at highest grade
// - non fire, non 24h zones are burglary
// - instant zone alarms armed eligible partitions
// - entry zone starts longest entry delay
// - entry path silent during entry delay
// - exit delay zone silent during exit
// - last exit restarts last exit timer
// - 24h zone alarms regardless of arming
// - fire forces 24h open-idle, fire alarm
// - hold-up events never drive output 1
// - hold-up active blocks normal arming
// - hold-up with fault option: fault only
// - cycle limit 0 to 255, 255 unlimited
// - test zone logs test record instead
`timescale 1ns/1ps
module alarm_zone_evaluator
(
  input  wire logic                                                clk,
  input  wire logic                                                rstn,
  input  wire zone_eval_pkg::line_type   [zone_eval_pkg::NZONE-1:0] line_raw,
  input  wire zone_eval_pkg::zcfg_type   [zone_eval_pkg::NZONE-1:0] zone_cfg,
  input  wire zone_eval_pkg::pstate_type [zone_eval_pkg::NPART-1:0] part_state,
  input  wire logic                                                grade_high,
  input  wire logic [zone_eval_pkg::NZONE-1:0]                     cycle_reload,
  input  wire logic                                                arm_req,
  input  wire logic                                                arm_forced,
  output logic                                                     arm_ok,
  output zone_eval_pkg::zstate_type [zone_eval_pkg::NZONE-1:0]     zone_state,
  output logic [zone_eval_pkg::NZONE-1:0]                          zone_burglary,
  output logic [zone_eval_pkg::NZONE-1:0]                          ev_zone_alarm,
  output logic [zone_eval_pkg::NZONE-1:0]                          ev_zone_tamper,
  output logic [zone_eval_pkg::NZONE-1:0]                          ev_zone_test,
  output logic [zone_eval_pkg::NZONE-1:0]                          ev_detector_fault,
  output logic [zone_eval_pkg::NZONE-1:0]                          ev_holdup,
  output logic                                                     ev_sys_fault,
  output logic [zone_eval_pkg::NPART-1:0]                          ev_part_alarm,
  output logic [zone_eval_pkg::NPART-1:0]                          ev_part_tamper,
  output logic [zone_eval_pkg::NPART-1:0]                          ev_part_fire,
  output logic [zone_eval_pkg::NPART-1:0]                          entry_start,
  output logic [zone_eval_pkg::NPART-1:0]                          last_exit_start,
  output logic                                                     out1_alarm
);
  import zone_eval_pkg::*;
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst1_q;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst1_q <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst1_q <= 1'b1;
      rst_n  <= rst1_q;
    end
  end

  // ----------------------------------------------------------------
  // line filtering and classification
  // ----------------------------------------------------------------
  line_type   [NZONE-1:0] line_s;
  zstate_type [NZONE-1:0] cls;
  balance_type [NZONE-1:0] bal_eff;

  genvar gz;
  generate
    for (gz = 0; gz < NZONE; gz++) begin : g_filt
      zone_filter u_filt (
        .clk    (clk),
        .rst_n  (rst_n),
        .raw    (line_raw[gz]),
        .stable (line_s[gz])
      );
    end
  endgenerate

  // decode line condition per effective balance
  always_comb begin
    for (int z = 0; z < NZONE; z++) begin
      bal_eff[z] = zone_cfg[z].balance;
      if (zone_cfg[z].ztype == ZT_FIRE)
        bal_eff[z] = BAL_OPEN_IDLE;
      else if (zone_cfg[z].balance == BAL_TRIPLE_R && !grade_high)
        bal_eff[z] = BAL_DOUBLE_R;
      cls[z] = ST_ALARM;
      case (bal_eff[z])
        BAL_OPEN_IDLE:
          cls[z] = (line_s[z] == LINE_SHORT) ? ST_ALARM : ST_STANDBY;
        BAL_CLOSED_IDLE:
          cls[z] = (line_s[z] == LINE_SHORT) ? ST_STANDBY : ST_ALARM;
        BAL_SINGLE_R: begin
          if (line_s[z] == LINE_ONE_R)      cls[z] = ST_STANDBY;
          else if (line_s[z] == LINE_SHORT) cls[z] = ST_TAMPER;
          else                              cls[z] = ST_ALARM;
        end
        BAL_DOUBLE_R, BAL_TRIPLE_R: begin
          if (line_s[z] == LINE_TWO_R)      cls[z] = ST_STANDBY;
          else if (line_s[z] == LINE_ONE_R) cls[z] = ST_ALARM;
          else if (line_s[z] == LINE_FAULT && bal_eff[z] == BAL_TRIPLE_R)
            cls[z] = ST_FAULT;
          else                              cls[z] = ST_TAMPER;
        end
        default: cls[z] = ST_ALARM;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per-zone state, edge detect, cycle counters
  // ----------------------------------------------------------------
  zstate_type [NZONE-1:0] st_q;
  logic [NZONE-1:0][7:0]  cyc_q;
  logic [NZONE-1:0]       viol_new;
  logic [NZONE-1:0]       tamp_new;
  logic [NZONE-1:0]       fault_new;
  logic [NZONE-1:0]       alarm_fire;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= cls;
    end
  end

  always_comb begin
    for (int z = 0; z < NZONE; z++) begin
      viol_new[z]  = (cls[z] == ST_ALARM)  && (st_q[z] != ST_ALARM);
      tamp_new[z]  = (cls[z] == ST_TAMPER) && (st_q[z] != ST_TAMPER);
      fault_new[z] = (cls[z] == ST_FAULT)  && (st_q[z] != ST_FAULT);
    end
  end

  // cycle budget per zone, reloaded by software on partition events
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= '0;
    end else begin
      for (int z = 0; z < NZONE; z++) begin
        if (cycle_reload[z])
          cyc_q[z] <= zone_cfg[z].cycles;
        else if (alarm_fire[z] && zone_cfg[z].cycles != CYC_UNLIMITED)
          cyc_q[z] <= cyc_q[z] - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // zone type evaluation
  // ----------------------------------------------------------------
  logic [NZONE-1:0]       elig;
  logic [NZONE-1:0]       arm_all;
  logic [NZONE-1:0]       in_entry;
  logic [NZONE-1:0]       in_exit;
  logic [NZONE-1:0]       is_24;
  logic [NZONE-1:0]       go_inst;
  logic [NZONE-1:0]       go_test;
  logic [NZONE-1:0]       go_entry;
  logic [NZONE-1:0]       go_last;
  logic [NPART-1:0]       armed_v;
  logic [NPART-1:0]       entry_v;
  logic [NPART-1:0]       exit_v;
  logic [NZONE-1:0]       burg_d;

  always_comb begin
    for (int p = 0; p < NPART; p++) begin
      armed_v[p] = part_state[p].armed;
      entry_v[p] = part_state[p].entry_run;
      exit_v[p]  = part_state[p].exit_run;
    end
  end

  always_comb begin
    for (int z = 0; z < NZONE; z++) begin
      burg_d[z]   = !(zone_cfg[z].ztype == ZT_FIRE || zone_cfg[z].ztype == ZT_H24);
      is_24[z]    = zone_cfg[z].ztype inside {ZT_H24, ZT_FIRE, ZT_HOLDUP};
      arm_all[z]  = (zone_cfg[z].parts != '0) && ((zone_cfg[z].parts & ~armed_v) == '0);
      in_entry[z] = |(zone_cfg[z].parts & entry_v);
      in_exit[z]  = |(zone_cfg[z].parts & exit_v);
      elig[z]     = !zone_cfg[z].bypass && (cyc_q[z] != CYC_NONE);
      go_inst[z]  = 1'b0;
      go_entry[z] = 1'b0;
      go_last[z]  = 1'b0;
      if (viol_new[z] && elig[z]) begin
        case (zone_cfg[z].ztype)
          ZT_INSTANT:    go_inst[z] = arm_all[z];
          ZT_ENTRY: begin
            go_entry[z] = arm_all[z] && !in_entry[z];
            go_inst[z]  = arm_all[z] && in_entry[z];
          end
          ZT_ENTRY_PATH: go_inst[z] = arm_all[z] && !in_entry[z];
          ZT_EXIT:       go_inst[z] = arm_all[z] && !in_exit[z];
          ZT_LAST_EXIT: begin
            go_last[z] = in_exit[z];
            go_inst[z] = arm_all[z] && !in_exit[z];
          end
          ZT_HOLDUP:     go_inst[z] = !zone_cfg[z].fault_opt;
          default:       go_inst[z] = 1'b1;
        endcase
      end
      go_test[z]    = go_inst[z] && zone_cfg[z].test;
      alarm_fire[z] = go_inst[z] && !zone_cfg[z].test;
    end
  end

  // burglary class flag, held in a flop like all other outputs except arm_ok
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zone_burglary <= '0;
    end else begin
      zone_burglary <= burg_d;
    end
  end

  // ----------------------------------------------------------------
  // event registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_zone_alarm     <= '0;
      ev_zone_tamper    <= '0;
      ev_zone_test      <= '0;
      ev_detector_fault <= '0;
      ev_holdup         <= '0;
    end else begin
      ev_zone_alarm     <= alarm_fire;
      ev_zone_tamper    <= tamp_new;
      ev_zone_test      <= go_test;
      for (int z = 0; z < NZONE; z++) begin
        ev_detector_fault[z] <= viol_new[z] && elig[z] && zone_cfg[z].ztype == ZT_HOLDUP
                                && zone_cfg[z].fault_opt;
        ev_holdup[z] <= alarm_fire[z] && zone_cfg[z].ztype == ZT_HOLDUP;
      end
    end
  end

  // partition events gathered over zones
  logic [NPART-1:0] pa_d;
  logic [NPART-1:0] pt_d;
  logic [NPART-1:0] pf_d;
  logic [NPART-1:0] es_d;
  logic [NPART-1:0] le_d;
  logic             o1_d;

  always_comb begin
    pa_d = '0;
    pt_d = '0;
    pf_d = '0;
    es_d = '0;
    le_d = '0;
    o1_d = 1'b0;
    for (int z = 0; z < NZONE; z++) begin
      if (tamp_new[z])
        pt_d = pt_d | zone_cfg[z].parts;
      if (alarm_fire[z]) begin
        if (zone_cfg[z].ztype == ZT_FIRE)
          pf_d = pf_d | zone_cfg[z].parts;
        else if (is_24[z])
          pa_d = pa_d | zone_cfg[z].parts;
        else
          pa_d = pa_d | (zone_cfg[z].parts & armed_v);
        if (zone_cfg[z].ztype != ZT_HOLDUP)
          o1_d = 1'b1;
      end
      if (go_entry[z])
        es_d = es_d | zone_cfg[z].parts;
      if (go_last[z])
        le_d = le_d | (zone_cfg[z].parts & exit_v);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_part_alarm   <= '0;
      ev_part_tamper  <= '0;
      ev_part_fire    <= '0;
      entry_start     <= '0;
      last_exit_start <= '0;
      out1_alarm      <= 1'b0;
      ev_sys_fault    <= 1'b0;
    end else begin
      ev_part_alarm   <= pa_d;
      ev_part_tamper  <= pt_d;
      ev_part_fire    <= pf_d;
      entry_start     <= es_d;
      last_exit_start <= le_d;
      out1_alarm      <= o1_d;
      ev_sys_fault    <= |fault_new;
    end
  end

  // ----------------------------------------------------------------
  // arming gate and state view
  // ----------------------------------------------------------------
  logic holdup_active;

  always_comb begin
    holdup_active = 1'b0;
    for (int z = 0; z < NZONE; z++)
      if (zone_cfg[z].ztype == ZT_HOLDUP && st_q[z] == ST_ALARM && !zone_cfg[z].bypass)
        holdup_active = 1'b1;
  end

  assign arm_ok     = arm_req && (!holdup_active || arm_forced);
  assign zone_state = st_q;

  AST_HOLDUP_OUT1: assert property (@(posedge clk) disable iff (!rst_n)
    (alarm_fire == 8'h01 && zone_cfg[0].ztype == ZT_HOLDUP) |=> !out1_alarm)
    else $error("output 1 raised by a hold-up alarm");
  AST_ARM_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
    (holdup_active && !arm_forced) |-> !arm_ok)
    else $error("normal arming allowed with hold-up active");
  AST_CYC_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    (cyc_q[0] == CYC_NONE && !cycle_reload[0]) |=> !ev_zone_alarm[0])
    else $error("zone alarm with no cycles left");
  AST_CYC_DEC: assert property (@(posedge clk) disable iff (!rst_n)
    (alarm_fire[0] && !cycle_reload[0] && zone_cfg[0].cycles != CYC_UNLIMITED && $stable(zone_cfg[0].cycles))
    |=> cyc_q[0] == $past(cyc_q[0]) - 8'h01)
    else $error("cycle count not decremented");
  AST_TEST_NOALARM: assert property (@(posedge clk) disable iff (!rst_n)
    zone_cfg[0].test |=> !ev_zone_alarm[0] || !$past(zone_cfg[0].test))
    else $error("test zone raised alarm");
  AST_TAMPER_PART: assert property (@(posedge clk) disable iff (!rst_n)
    tamp_new[0] |=> ev_zone_tamper[0] && ((ev_part_tamper & $past(zone_cfg[0].parts)) == $past(zone_cfg[0].parts)))
    else $error("tamper events incomplete");
  AST_SINGLE_SHORT: assert property (@(posedge clk) disable iff (!rst_n)
    (bal_eff[0] == BAL_SINGLE_R && line_s[0] == LINE_SHORT) |-> cls[0] == ST_TAMPER)
    else $error("single balance short not tamper");
  AST_EXIT_SILENT: assert property (@(posedge clk) disable iff (!rst_n)
    (zone_cfg[0].ztype == ZT_EXIT && in_exit[0]) |-> !alarm_fire[0])
    else $error("exit zone alarm during exit delay");
  AST_PATH_SILENT: assert property (@(posedge clk) disable iff (!rst_n)
    (zone_cfg[0].ztype == ZT_ENTRY_PATH && in_entry[0]) |-> !alarm_fire[0])
    else $error("entry path zone alarm during entry delay");
  AST_BYPASS_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    zone_cfg[0].bypass |=> !ev_zone_alarm[0])
    else $error("bypassed zone raised alarm");
  AST_FIRE_BAL: assert property (@(posedge clk) disable iff (!rst_n)
    (zone_cfg[2].ztype == ZT_FIRE) |-> bal_eff[2] == BAL_OPEN_IDLE)
    else $error("fire zone not open-idle");
endmodule

// ==== tb/line_detector.sv ====
// zone line condition detector model feeding the evaluator
`timescale 1ns/1ps
module line_detector
(
  input  wire logic                                          clk,
  output zone_eval_pkg::line_type [zone_eval_pkg::NZONE-1:0] line_raw
);
  import zone_eval_pkg::*;
  // ----------------------------------------------------------------
  // every zone starts with an open line
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < NZONE; i++) line_raw[i] = LINE_OPEN;
  end

  // change one zone just after a rising edge, held until changed again
  task automatic set_line(input int zone, input line_type cond);
    @(posedge clk);
    #1;
    line_raw[zone] = cond;
  endtask
endmodule

// ==== tb/tb_top.sv ====
// self-checking testbench for the alarm zone evaluator
`timescale 1ns/1ps
module tb_top;
  import zone_eval_pkg::*;
  typedef struct {
    balance_type bal;
    ztype_type   zt;
    logic        tst, byp, rld, fopt;
    logic [7:0]  cyc;
    logic [2:0]  ps;
    logic [8:0]  exp;
  } row_type;
  typedef struct {
    balance_type bal;
    ztype_type   zt;
    logic        grade;
    zstate_type  st;
    logic        burg;
  } cls_type;
  logic                   clk          = 1'b0;
  logic                   rstn         = 1'b0;
  logic                   grade_high   = 1'b0;
  logic                   arm_req      = 1'b0;
  logic                   arm_forced   = 1'b0;
  logic [NZONE-1:0]       cycle_reload = '0;
  zcfg_type [NZONE-1:0]   zone_cfg;
  pstate_type [NPART-1:0] part_state   = '0;
  line_type [NZONE-1:0]   line_raw;
  zstate_type [NZONE-1:0] zone_state;
  logic                   arm_ok, ev_sys_fault, out1_alarm, seen, hu;
  logic [NZONE-1:0]       zone_burglary, ev_zone_alarm, ev_zone_tamper, ev_zone_test, ev_detector_fault, ev_holdup;
  logic [NPART-1:0]       ev_part_alarm, ev_part_tamper, ev_part_fire, entry_start, last_exit_start;
  logic [8:0]             obs;
  row_type                rows [16];
  cls_type                cls [7];
  int                     fails     = 0;
  int                     tests_run = 0;

  alarm_zone_evaluator uut (.clk(clk), .rstn(rstn), .line_raw(line_raw), .zone_cfg(zone_cfg),
    .part_state(part_state), .grade_high(grade_high), .cycle_reload(cycle_reload), .arm_req(arm_req),
    .arm_forced(arm_forced), .arm_ok(arm_ok), .zone_state(zone_state), .zone_burglary(zone_burglary),
    .ev_zone_alarm(ev_zone_alarm), .ev_zone_tamper(ev_zone_tamper), .ev_zone_test(ev_zone_test),
    .ev_detector_fault(ev_detector_fault), .ev_holdup(ev_holdup), .ev_sys_fault(ev_sys_fault),
    .ev_part_alarm(ev_part_alarm), .ev_part_tamper(ev_part_tamper), .ev_part_fire(ev_part_fire),
    .entry_start(entry_start), .last_exit_start(last_exit_start), .out1_alarm(out1_alarm));
  line_detector det (.clk(clk), .line_raw(line_raw));

  // ----------------------------------------------------------------
  // clock and helpers
  // ----------------------------------------------------------------
  always #10 clk = ~clk;

  // inputs always change 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // zone 0 and partition 0 event outputs in one vector
  function automatic logic [8:0] evs();
    return {ev_zone_alarm[0], ev_part_alarm[0], out1_alarm, ev_zone_test[0], entry_start[0],
            last_exit_start[0], ev_detector_fault[0], ev_zone_tamper[0], ev_part_tamper[0]};
  endfunction

  task automatic check_vec(input string what, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_st(input string what, input zstate_type exp, input zstate_type got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // zone 0 to standby with the row's set-up, then into the row's balance on an open line
  task automatic trip(input row_type r);
    zone_cfg[0].balance = BAL_OPEN_IDLE;
    zone_cfg[0].ztype = r.zt;
    zone_cfg[0].test = r.tst;
    zone_cfg[0].bypass = r.byp;
    zone_cfg[0].fault_opt = r.fopt;
    zone_cfg[0].cycles = r.cyc;
    part_state[0] = r.ps;
    cycle_reload[0] = r.rld;
    step(1);
    cycle_reload[0] = 1'b0;
    step(4);
    zone_cfg[0].balance = r.bal;
    obs = '0;
    hu = 1'b0;
    repeat (8) begin
      step(1);
      obs |= evs();
      hu |= ev_holdup[0];
    end
  endtask

  // ----------------------------------------------------------------
  // event rows: exp = alarm, part alarm, out1, test, entry, last exit, fault, tamper, part tamper
  // ----------------------------------------------------------------
  initial begin
    rows[0]  = '{BAL_CLOSED_IDLE, ZT_INSTANT,    0, 0, 1, 0, 8'h01, 3'h4, 9'h1C0};
    rows[1]  = '{BAL_CLOSED_IDLE, ZT_INSTANT,    0, 0, 0, 0, 8'h01, 3'h4, 9'h000};
    rows[2]  = '{BAL_CLOSED_IDLE, ZT_INSTANT,    0, 0, 1, 0, 8'h01, 3'h0, 9'h000};
    rows[3]  = '{BAL_CLOSED_IDLE, ZT_INSTANT,    0, 0, 1, 0, 8'h00, 3'h4, 9'h000};
    rows[4]  = '{BAL_CLOSED_IDLE, ZT_INSTANT,    0, 1, 1, 0, 8'h01, 3'h4, 9'h000};
    rows[5]  = '{BAL_CLOSED_IDLE, ZT_INSTANT,    1, 0, 1, 0, 8'h01, 3'h4, 9'h020};
    rows[6]  = '{BAL_CLOSED_IDLE, ZT_INSTANT,    0, 0, 1, 0, 8'hFF, 3'h4, 9'h1C0};
    rows[7]  = '{BAL_CLOSED_IDLE, ZT_INSTANT,    0, 0, 0, 0, 8'hFF, 3'h4, 9'h1C0};
    rows[8]  = '{BAL_CLOSED_IDLE, ZT_H24,        0, 0, 1, 0, 8'h05, 3'h0, 9'h1C0};
    rows[9]  = '{BAL_CLOSED_IDLE, ZT_HOLDUP,     0, 0, 1, 0, 8'hFF, 3'h0, 9'h180};
    rows[10] = '{BAL_CLOSED_IDLE, ZT_HOLDUP,     0, 0, 1, 1, 8'hFF, 3'h0, 9'h004};
    rows[11] = '{BAL_CLOSED_IDLE, ZT_ENTRY,      0, 0, 1, 0, 8'h01, 3'h4, 9'h010};
    rows[12] = '{BAL_CLOSED_IDLE, ZT_ENTRY_PATH, 0, 0, 1, 0, 8'h01, 3'h6, 9'h000};
    rows[13] = '{BAL_CLOSED_IDLE, ZT_EXIT,       0, 0, 1, 0, 8'h01, 3'h5, 9'h000};
    rows[14] = '{BAL_CLOSED_IDLE, ZT_LAST_EXIT,  0, 0, 1, 0, 8'h01, 3'h5, 9'h008};
    rows[15] = '{BAL_DOUBLE_R,    ZT_INSTANT,    0, 1, 1, 0, 8'h01, 3'h0, 9'h003};
    cls[0] = '{BAL_OPEN_IDLE,   ZT_INSTANT,   0, ST_STANDBY, 1};
    cls[1] = '{BAL_CLOSED_IDLE, ZT_INSTANT,   0, ST_ALARM,   1};
    cls[2] = '{BAL_SINGLE_R,    ZT_ENTRY,     0, ST_ALARM,   1};
    cls[3] = '{BAL_DOUBLE_R,    ZT_EXIT,      0, ST_TAMPER,  1};
    cls[4] = '{BAL_TRIPLE_R,    ZT_LAST_EXIT, 1, ST_TAMPER,  1};
    cls[5] = '{BAL_CLOSED_IDLE, ZT_FIRE,      0, ST_STANDBY, 0};
    cls[6] = '{BAL_OPEN_IDLE,   ZT_H24,       0, ST_STANDBY, 0};
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < NZONE; i++) zone_cfg[i] = '{BAL_OPEN_IDLE, ZT_INSTANT, 4'h0, 1'b0, 1'b0, 1'b0, 8'h00};
    zone_cfg[0].parts = 4'h1;
    zone_cfg[1].parts = 4'h2;
    step(8);
    check_vec("events in reset", 9'h000, evs());
    check_st("state in reset", ST_STANDBY, zone_state[0]);
    step(2);
    rstn = 1'b1;
    step(3);
    for (int i = 0; i < 16; i++) begin
      trip(rows[i]);
      check_vec($sformatf("events row %0d", i), rows[i].exp, obs);
      check_vec($sformatf("holdup row %0d", i), {8'h00, rows[i].exp[8] && rows[i].zt == ZT_HOLDUP}, {8'h00, hu});
    end
    // line classification per balance on an open line
    for (int i = 0; i < 7; i++) begin
      zone_cfg[2].balance = cls[i].bal;
      zone_cfg[2].ztype = cls[i].zt;
      grade_high = cls[i].grade;
      step(4);
      check_st($sformatf("state class %0d", i), cls[i].st, zone_state[2]);
      check_vec($sformatf("burglary class %0d", i), {8'h00, cls[i].burg}, {8'h00, zone_burglary[2]});
    end
    // active hold-up zone blocks normal arming only
    zone_cfg[0].ztype = ZT_HOLDUP;
    zone_cfg[0].balance = BAL_CLOSED_IDLE;
    zone_cfg[0].bypass = 1'b0;
    arm_req = 1'b1;
    step(4);
    check_vec("arm while hold-up", 9'h000, {8'h00, arm_ok});
    arm_forced = 1'b1;
    step(1);
    check_vec("forced arm while hold-up", 9'h001, {8'h00, arm_ok});
    zone_cfg[0].balance = BAL_OPEN_IDLE;
    arm_forced = 1'b0;
    step(4);
    check_vec("arm without hold-up", 9'h001, {8'h00, arm_ok});
    // a short on zone 1 is not acted on well inside the persistence time
    zone_cfg[1].cycles = 8'hFF;
    part_state[1] = 3'h4;
    cycle_reload[1] = 1'b1;
    step(1);
    cycle_reload[1] = 1'b0;
    det.set_line(1, LINE_SHORT);
    seen = 1'b0;
    repeat (20000) begin
      step(1);
      seen |= ev_zone_alarm[1] | ev_part_alarm[1] | (zone_state[1] !== ST_STANDBY);
    end
    check_vec("early line action", 9'h000, {8'h00, seen});
    // second reset in mid-run clears the zone state
    zone_cfg[0].balance = BAL_CLOSED_IDLE;
    step(4);
    rstn = 1'b0;
    step(2);
    check_st("state after reset", ST_STANDBY, zone_state[0]);
    check_vec("events after reset", 9'h000, evs());
    // release again: the violated zone shows alarm, but reset left it no cycle budget
    rstn = 1'b1;
    step(3);
    check_st("state after release", ST_ALARM, zone_state[0]);
    check_vec("events after release", 9'h000, evs());
    test_done();
  end

  // watchdog sized well above the expected run of about 20300 cycles
  initial begin
    step(50000);
    fails++;
    $display("unexpected timeout: expected end seen none");
    test_done();
  end
endmodule
